// *** verilog/dtcs_top.sv ***
// What this block does
// - full flag sets once 64 or more lines are stored since arming
// - while full flag is set, all 64 lines count as valid
// - writing one to the arm bit clears line count, and full flag unless the count wraps in that cycle
// - only power-on reset clears full flag; other resets keep it
// - only power-on reset clears line count; other resets keep it
// - full flag also reads as bit 7 of the debug status register
// - line count sits in bits 5..0, number of valid 20-bit lines
// - count wrap to zero sets full; end alignment keeps counting
// - reading the trace buffer never decrements the count
// - count register is always readable, writes do nothing
// - begin alignment: full with count zero clears arm, ends session
// - full with nonzero count shows 64 lines, oldest overwritten
// - states 1..3 each own a next-state control register
// - state tables and match flags share one address, bank selects
// - state 1 register readable at bank 00, writable only disarmed
// - four-bit code in bits 3..0 picks state 1 targets per match
// - codes 0000..0011: any to final, m1 s3, m2 s2, m1 s2
// - codes 0100..0111: mixed targets for match 0, 1 and 2
// - codes 1001 and 1101 defined, the other high codes reserved
// - matches not named by the code cause no transition
// - simultaneous matches: final wins, then lowest channel
`timescale 1ns/1ps
`include "dtcs_defs.svh"

module dtcs_top (
	input wire logic sys_clk_i,
	input wire logic rst_i,
	input wire logic sys_reset_i,
	input wire logic hsel_i,
	input wire logic [31:0] haddr_i,
	input wire logic [1:0] htrans_i,
	input wire logic [2:0] hsize_i,
	input wire logic hwrite_i,
	input wire logic hready_i,
	input wire logic [31:0] hwdata_i,
	output logic [31:0] hrdata_o,
	output logic hreadyout_o,
	output logic hresp_o,
	input wire logic line_stored_i,
	input wire logic in_state1_i,
	input wire logic [2:0] match_i,
	output dtcs_pkg::dtcs_seq_req_s seq_req_o,
	output logic armed_o,
	output logic [1:0] bank_sel_o,
	output logic align_begin_o,
	output logic session_end_o,
	output logic [6:0] valid_lines_o,
	output logic overwritten_o
);
	import dtcs_pkg::*;

	function automatic logic reg_hit(input logic [31:0] a, input logic [7:0] idx);
		return a == {22'h000000, idx, 2'b00};
	endfunction

	// per-channel targets {match2, match1, match0} for each state 1 code
	function automatic logic [8:0] code_map(input logic [3:0] code);
		logic [8:0] m;
		m = {dtcs_st_none, dtcs_st_none, dtcs_st_none};
		case (code)
			4'h0: m = {dtcs_st_final, dtcs_st_final, dtcs_st_final};
			4'h1: m = {dtcs_st_none, dtcs_st_three, dtcs_st_none};
			4'h2: m = {dtcs_st_two, dtcs_st_none, dtcs_st_none};
			4'h3: m = {dtcs_st_none, dtcs_st_two, dtcs_st_none};
			4'h4: m = {dtcs_st_none, dtcs_st_three, dtcs_st_two};
			4'h5: m = {dtcs_st_none, dtcs_st_three, dtcs_st_final};
			4'h6: m = {dtcs_st_three, dtcs_st_none, dtcs_st_two};
			4'h7: m = {dtcs_st_none, dtcs_st_two, dtcs_st_two};
			4'h9: m = {dtcs_st_none, dtcs_st_none, dtcs_st_three};
			4'hD: m = {dtcs_st_final, dtcs_st_two, dtcs_st_final};
			default: m = {dtcs_st_none, dtcs_st_none, dtcs_st_none};
		endcase
		return m;
	endfunction

	// final state first, then the lowest matching channel with a target
	function automatic dtcs_seq_e state1_pick(input logic [3:0] code, input logic [2:0] m);
		logic [8:0] map;
		dtcs_seq_e t;
		dtcs_seq_e pick;
		map = code_map(code);
		pick = dtcs_st_none;
		for (int ch = 2; ch >= 0; ch--) begin
			t = dtcs_seq_e'(map[ch*3 +: 3]);
			if (m[ch] && t != dtcs_st_none) begin
				pick = t;
			end
		end
		for (int ch = 0; ch < 3; ch++) begin
			t = dtcs_seq_e'(map[ch*3 +: 3]);
			if (m[ch] && t == dtcs_st_final) begin
				pick = dtcs_st_final;
			end
		end
		return pick;
	endfunction

	dtcs_ahb_req_s req;
	logic armed;
	logic align_begin;
	logic [1:0] bank;
	logic full;
	logic [5:0] count;
	logic [3:0] code;

	// bus address and data phase
	wire addr_take = hsel_i & hready_i & (htrans_i == `DTCS_HTRANS_NONSEQ)
		& (hsize_i == `DTCS_HSIZE_WORD);
	wire rd_take = addr_take & ~hwrite_i;
	wire wr_en = req.valid & req.write;
	wire ctrl_wr = wr_en & reg_hit(req.addr, `DTCS_IDX_CTRL);
	wire scr1_wr_try = wr_en & reg_hit(req.addr, `DTCS_IDX_SCR1);
	wire scr1_wr = scr1_wr_try & (bank == `DTCS_BANK_STATE1) & ~armed;
	wire arm_wr_one = ctrl_wr & hwdata_i[`DTCS_CTRL_ARM_BIT];

	wire [7:0] ctrl_byte = {armed, 4'h0, align_begin, bank};
	wire [7:0] status_byte = {full, 7'h00};
	wire [7:0] count_byte = {full, 1'b0, count};
	wire [7:0] scr1_byte = (bank == `DTCS_BANK_STATE1) ? {4'h0, code} : 8'h00;
	wire [7:0] rd_byte = reg_hit(haddr_i, `DTCS_IDX_CTRL) ? ctrl_byte
		: reg_hit(haddr_i, `DTCS_IDX_STATUS) ? status_byte
		: reg_hit(haddr_i, `DTCS_IDX_COUNT) ? count_byte
		: reg_hit(haddr_i, `DTCS_IDX_SCR1) ? scr1_byte
		: 8'h00;

	// trace line counting
	wire line_inc = line_stored_i & armed;
	wire wrap = line_inc & (count == `DTCS_COUNT_MAX);
	wire session_end = wrap & align_begin;
	// arming restarts the count even if a line lands in the same cycle
	wire [5:0] next_count = arm_wr_one ? `DTCS_COUNT_RST
		: line_inc ? count + 6'h01
		: count;
	wire next_full = wrap | (full & ~arm_wr_one);
	wire next_armed = sys_reset_i ? 1'b0
		: ctrl_wr ? hwdata_i[`DTCS_CTRL_ARM_BIT]
		: session_end ? 1'b0
		: armed;
	wire [6:0] next_valid_lines = next_full ? `DTCS_LINES_ALL : {1'b0, next_count};
	wire next_overwritten = next_full & (next_count != `DTCS_COUNT_RST);

	// state 1 sequencing
	wire dtcs_seq_e pick = state1_pick(code, match_i);
	wire fire = armed & in_state1_i & (pick != dtcs_st_none) & ~sys_reset_i;

	always_ff @(posedge sys_clk_i or posedge rst_i) begin
		if (rst_i) begin
			req <= '0;
			hrdata_o <= 32'h00000000;
			hreadyout_o <= 1'b1;
			hresp_o <= 1'b0;
		end else begin
			req <= '{valid: addr_take, write: hwrite_i, addr: haddr_i};
			if (rd_take) begin
				hrdata_o <= {24'h000000, rd_byte};
			end
		end
	end

	always_ff @(posedge sys_clk_i or posedge rst_i) begin
		if (rst_i) begin
			armed <= 1'b0;
			bank <= `DTCS_BANK_RST;
			align_begin <= 1'b0;
			code <= `DTCS_CODE_RST;
		end else begin
			armed <= next_armed;
			if (ctrl_wr) begin
				bank <= hwdata_i[`DTCS_CTRL_BANK_MSB:`DTCS_CTRL_BANK_LSB];
			end
			if (ctrl_wr && !armed) begin
				align_begin <= hwdata_i[`DTCS_CTRL_ALIGN_BIT];
			end
			if (scr1_wr) begin
				code <= hwdata_i[3:0];
			end
		end
	end

	// only the power-on reset touches these; sys_reset_i is ignored here
	always_ff @(posedge sys_clk_i or posedge rst_i) begin
		if (rst_i) begin
			full <= 1'b0;
			count <= `DTCS_COUNT_RST;
			valid_lines_o <= 7'h00;
			overwritten_o <= 1'b0;
		end else begin
			full <= next_full;
			count <= next_count;
			valid_lines_o <= next_valid_lines;
			overwritten_o <= next_overwritten;
		end
	end

	always_ff @(posedge sys_clk_i or posedge rst_i) begin
		if (rst_i) begin
			seq_req_o <= '{go: 1'b0, target: dtcs_st_none};
			session_end_o <= 1'b0;
		end else begin
			seq_req_o <= '{go: fire, target: fire ? pick : dtcs_st_none};
			session_end_o <= session_end & ~sys_reset_i & ~ctrl_wr;
		end
	end

	assign armed_o = armed;
	assign bank_sel_o = bank;
	assign align_begin_o = align_begin;

	default clocking cb @(posedge sys_clk_i);
	endclocking
	default disable iff (rst_i);

	a_full_on_wrap: assert property (
		line_stored_i && armed && count == 6'h3F |=> full && count == 6'h00
	) else $error("full flag not set on count wrap");

	a_arm_clears: assert property (
		arm_wr_one && !wrap |=> count == 6'h00 && !full && valid_lines_o == 7'h00
	) else $error("arming did not clear count and full flag");

	a_sysrst_keeps: assert property (
		sys_reset_i && !line_inc && !arm_wr_one |=> $stable(count) && $stable(full) && !armed
	) else $error("system reset disturbed count or full flag");

	a_status_mirror: assert property (
		rd_take && reg_hit(haddr_i, 8'h21) ##2 rd_take && reg_hit(haddr_i, 8'h26)
		&& full == $past(full, 2) |=> hrdata_o[7] == $past(hrdata_o[7], 2)
	) else $error("status bit 7 differs from count bit 7");

	a_count_no_dec: assert property (
		!arm_wr_one && !wrap |=> count >= $past(count)
	) else $error("line count went down");

	a_count_readonly: assert property (
		wr_en && reg_hit(req.addr, 8'h26) && !line_inc && !arm_wr_one |=> $stable(count)
	) else $error("write changed the line count");

	a_begin_ends: assert property (
		wrap && align_begin && !ctrl_wr && !sys_reset_i |=> !armed && session_end_o
		##1 !session_end_o
	) else $error("begin alignment session did not end at full");

	a_lines_shown: assert property (
		full && count != 6'h00 && !arm_wr_one && !line_inc |=>
		valid_lines_o == 7'h40 && overwritten_o
	) else $error("full buffer not shown as 64 lines");

	a_scr1_locked: assert property (
		scr1_wr_try && (armed || bank != 2'h0) |=> $stable(code)
	) else $error("state 1 code written while locked");

	a_final_wins: assert property (
		armed && in_state1_i && !sys_reset_i && code == 4'hD && match_i[0] && match_i[1]
		|=> seq_req_o.go && seq_req_o.target == dtcs_st_final ##1 seq_req_o.go == $past(fire)
	) else $error("final state lost priority");

	a_unnamed_idle: assert property (
		(code == 4'h8 || code == 4'hA || code == 4'hF || code == 4'h1 && !match_i[1])
		|=> !seq_req_o.go
	) else $error("unnamed match caused a transition");

	// bus answer and read-back
	a_bus_okay: assert property (
		hreadyout_o && !hresp_o
	) else $error("bus answer not ready or not okay");

	a_rd_upper_zero: assert property (
		rd_take |=> hrdata_o[31:8] == 24'h000000
	) else $error("read data upper bits not zero");

	a_scr1_hidden: assert property (
		rd_take && reg_hit(haddr_i, 8'h27) && bank != 2'h0
		|=> hrdata_o == 32'h00000000
	) else $error("state 1 code visible in another bank");

	a_scr1_write: assert property (
		scr1_wr |=> code == $past(hwdata_i[3:0])
	) else $error("state 1 code not taken from write data");

	a_count_step: assert property (
		line_inc && !arm_wr_one && count != 6'h3F |=> count == $past(count) + 6'h01
	) else $error("line count did not step by one");

	a_count_idle: assert property (
		!armed && !arm_wr_one |=> $stable(count)
	) else $error("line count moved while disarmed");

	a_full_sticky: assert property (
		full && !arm_wr_one |=> full
	) else $error("full flag dropped without arming");

	a_count_read: assert property (
		rd_take && reg_hit(haddr_i, 8'h26)
		|=> hrdata_o[5:0] == $past(count) && hrdata_o[7] == $past(full)
	) else $error("count register read wrong");

	a_status_read: assert property (
		rd_take && reg_hit(haddr_i, 8'h21)
		|=> hrdata_o[7] == $past(full) && hrdata_o[6:0] == 7'h00
	) else $error("status register read wrong");

	a_end_keeps: assert property (
		wrap && !align_begin && !ctrl_wr && !sys_reset_i
		|=> armed && full && count == 6'h00
	) else $error("end alignment stopped on wrap");

	a_lines_count: assert property (
		!full |-> valid_lines_o == {1'b0, count}
	) else $error("valid lines differ from count");

	// sequencer
	a_seq_idle: assert property (
		!armed || !in_state1_i || sys_reset_i |=> !seq_req_o.go
	) else $error("transition outside armed state 1");

	a_any_final: assert property (
		armed && in_state1_i && !sys_reset_i && code == 4'h0 && match_i != 3'h0
		|=> seq_req_o.go && seq_req_o.target == dtcs_st_final
	) else $error("code 0000 did not go to final");

	a_code9_three: assert property (
		armed && in_state1_i && !sys_reset_i && code == 4'h9 && match_i[0]
		|=> seq_req_o.go && seq_req_o.target == dtcs_st_three
	) else $error("code 1001 did not go to state 3");

	a_code4_low: assert property (
		armed && in_state1_i && !sys_reset_i && code == 4'h4 && match_i[0]
		|=> seq_req_o.go && seq_req_o.target == dtcs_st_two
	) else $error("code 0100 lowest channel lost");

	a_sysrst_quiet: assert property (
		sys_reset_i |=> !seq_req_o.go && !session_end_o && !armed
	) else $error("system reset left sequencer active");

	a_align_locked: assert property (
		ctrl_wr && armed |=> $stable(align_begin)
	) else $error("alignment changed while armed");

	a_session_pulse: assert property (
		session_end_o |=> !session_end_o
	) else $error("session end pulse too long");

endmodule

// *** verilog/dtcs_defs.svh ***
`ifndef DTCS_DEFS_SVH
`define DTCS_DEFS_SVH

// register indices; byte address is four times the index
`define DTCS_IDX_CTRL 8'h20
`define DTCS_IDX_STATUS 8'h21
`define DTCS_IDX_COUNT 8'h26
`define DTCS_IDX_SCR1 8'h27

// debug_control_one fields
`define DTCS_CTRL_ARM_BIT 7
`define DTCS_CTRL_ALIGN_BIT 2
`define DTCS_CTRL_BANK_MSB 1
`define DTCS_CTRL_BANK_LSB 0

// debug_status_reg and trace_line_counter fields
`define DTCS_STATUS_FULL_BIT 7
`define DTCS_COUNT_FULL_BIT 7
`define DTCS_COUNT_MSB 5

// bank selector values and reset values
`define DTCS_BANK_STATE1 2'h0
`define DTCS_BANK_RST 2'h0
`define DTCS_CODE_RST 4'h0
`define DTCS_COUNT_RST 6'h00
`define DTCS_COUNT_MAX 6'h3F
`define DTCS_LINES_ALL 7'h40

// bus encodings
`define DTCS_HTRANS_NONSEQ 2'h2
`define DTCS_HSIZE_WORD 3'h2

`endif

// *** verilog/dtcs_pkg.sv ***
package dtcs_pkg;

	typedef enum logic [2:0] {
		dtcs_st_none = 3'b000,
		dtcs_st_one = 3'b001,
		dtcs_st_two = 3'b010,
		dtcs_st_three = 3'b011,
		dtcs_st_final = 3'b100
	} dtcs_seq_e;

	typedef struct packed {
		logic valid;
		logic write;
		logic [31:0] addr;
	} dtcs_ahb_req_s;

	typedef struct packed {
		logic go;
		dtcs_seq_e target;
	} dtcs_seq_req_s;

endpackage

// *** test/tb_dtcs_top.sv ***
`timescale 1ns/1ps
module tb_dtcs_top;
	import dtcs_pkg::*;
	logic sys_clk_i, rst_i, sys_reset_i, hsel_i, hwrite_i, line_stored_i, in_state1_i;
	logic [31:0] haddr_i, hwdata_i, hrdata_o, rd;
	logic [1:0] htrans_i, bank_sel_o;
	logic [2:0] hsize_i, match_i;
	logic hreadyout_o, hresp_o, armed_o, align_begin_o, session_end_o, overwritten_o;
	logic [6:0] valid_lines_o;
	wire logic hready_i;
	dtcs_seq_req_s seq_req_o;
	int failures, check_count, i, n;
	// code, match channels, go with target
	logic [11:0] rows [20] = '{12'h01C, 12'h12B, 12'h110, 12'h24A, 12'h32A, 12'h41A, 12'h46B,
		12'h53C, 12'h65A, 12'h72A, 12'h91B, 12'h960, 12'hD3C, 12'hD2A, 12'h870, 12'hA70,
		12'hB70, 12'hC70, 12'hE70, 12'hF70};

	assign hready_i = hreadyout_o;

	dtcs_top DUT (.sys_clk_i(sys_clk_i), .rst_i(rst_i), .sys_reset_i(sys_reset_i),
		.hsel_i(hsel_i), .haddr_i(haddr_i), .htrans_i(htrans_i), .hsize_i(hsize_i),
		.hwrite_i(hwrite_i), .hready_i(hready_i), .hwdata_i(hwdata_i), .hrdata_o(hrdata_o),
		.hreadyout_o(hreadyout_o), .hresp_o(hresp_o), .line_stored_i(line_stored_i),
		.in_state1_i(in_state1_i), .match_i(match_i), .seq_req_o(seq_req_o),
		.armed_o(armed_o), .bank_sel_o(bank_sel_o), .align_begin_o(align_begin_o),
		.session_end_o(session_end_o), .valid_lines_o(valid_lines_o),
		.overwritten_o(overwritten_o));

	initial begin
		sys_clk_i = 1'b0;
		forever #2.5 sys_clk_i = ~sys_clk_i;
	end

	task check(input string name, input logic [31:0] seen, input logic [31:0] exp);
		check_count++;
		if (seen !== exp) begin
			failures++;
			$display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
		end
	endtask

	task give_verdict;
		$display("checks %0d failures %0d", check_count, failures);
		if (failures == 0 && check_count > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask

	// waits for an edge with hready high, bounded
	task wait_ready;
		n = 0;
		do begin
			@(posedge sys_clk_i);
			n++;
		end while (hreadyout_o !== 1'b1 && n < 50);
		if (hreadyout_o !== 1'b1) begin
			failures++;
			give_verdict;
		end
	endtask

	task bus(input logic wr, input logic [31:0] a, input logic [31:0] d);
		hsel_i <= 1'b1;
		haddr_i <= a;
		htrans_i <= 2'h2;
		hwrite_i <= wr;
		wait_ready;
		htrans_i <= 2'h0;
		hsel_i <= 1'b0;
		hwdata_i <= d;
		wait_ready;
		rd = hrdata_o;
	endtask

	task store(input int k);
		line_stored_i <= 1'b1;
		repeat (k) @(posedge sys_clk_i);
		line_stored_i <= 1'b0;
		@(posedge sys_clk_i);
	endtask

	initial begin
		{rst_i, sys_reset_i, hsel_i, hwrite_i, line_stored_i} = 5'h10;
		{haddr_i, hwdata_i, htrans_i, match_i} = '0;
		hsize_i = 3'h2;
		in_state1_i = 1'b1;
		repeat (8) @(posedge sys_clk_i);
		rst_i <= 1'b0;
		@(posedge sys_clk_i);
		bus(0, 32'h98, 32'h0);
		check("count after reset", rd, 32'h0);
		check("bus response", hresp_o, 1'b0);
		for (i = 0; i < 20; i++) begin
			bus(1, 32'h80, 32'h0);
			bus(1, 32'h9C, {28'h0, rows[i][11:8]});
			bus(1, 32'h80, 32'h80);
			match_i <= rows[i][6:4];
			@(posedge sys_clk_i);
			in_state1_i <= 1'b0;
			#1;
			check("seq go", seq_req_o.go, rows[i][3]);
			if (rows[i][3])
				check("seq target", seq_req_o.target, rows[i][2:0]);
			@(posedge sys_clk_i);
			match_i <= 3'h0;
			in_state1_i <= 1'b1;
			#1;
			check("seq outside state 1", seq_req_o.go, 1'b0);
			@(posedge sys_clk_i);
		end
		bus(1, 32'h80, 32'h80);
		store(3);
		bus(0, 32'h98, 32'h0);
		check("count 3", rd, 32'h3);
		check("valid 3", valid_lines_o, 7'h03);
		bus(1, 32'h98, 32'hFF);
		bus(0, 32'h98, 32'h0);
		check("count write ignored", rd, 32'h3);
		store(61);
		bus(0, 32'h98, 32'h0);
		check("count wrap", rd, 32'h80);
		bus(0, 32'h84, 32'h0);
		check("status full", rd, 32'h80);
		bus(0, 32'h98, 32'h0);
		check("count after status", rd, 32'h80);
		check("valid full", valid_lines_o, 7'h40);
		store(1);
		bus(0, 32'h98, 32'h0);
		check("count after wrap", rd, 32'h81);
		check("overwritten", overwritten_o, 1'b1);
		sys_reset_i <= 1'b1;
		@(posedge sys_clk_i);
		sys_reset_i <= 1'b0;
		@(posedge sys_clk_i);
		check("armed after sys reset", armed_o, 1'b0);
		store(2);
		bus(0, 32'h98, 32'h0);
		check("count kept", rd, 32'h81);
		bus(1, 32'h80, 32'h01);
		@(posedge sys_clk_i);
		check("bank select", bank_sel_o, 2'h1);
		bus(1, 32'h9C, 32'h5);
		bus(0, 32'h9C, 32'h0);
		check("bank 01 read", rd, 32'h0);
		bus(1, 32'h80, 32'h80);
		bus(1, 32'h9C, 32'h3);
		bus(0, 32'h9C, 32'h0);
		check("code kept", rd, 32'hF);
		bus(0, 32'h98, 32'h0);
		check("arm clears", rd, 32'h0);
		bus(0, 32'h00, 32'h0);
		check("unmapped read", rd, 32'h0);
		bus(1, 32'h80, 32'h04);
		bus(1, 32'h80, 32'h84);
		@(posedge sys_clk_i);
		check("align begin", align_begin_o, 1'b1);
		check("armed begin", armed_o, 1'b1);
		line_stored_i <= 1'b1;
		repeat (64) @(posedge sys_clk_i);
		line_stored_i <= 1'b0;
		#1;
		n = 0;
		while (session_end_o !== 1'b1 && n < 4) begin
			@(posedge sys_clk_i);
			#1;
			n++;
		end
		check("session end", session_end_o, 1'b1);
		@(posedge sys_clk_i);
		check("disarmed at end", armed_o, 1'b0);
		bus(0, 32'h98, 32'h0);
		check("full zero count", rd, 32'h80);
		hsize_i <= 3'h0;
		bus(1, 32'h9C, 32'h2);
		hsize_i <= 3'h2;
		bus(0, 32'h9C, 32'h0);
		check("byte write ignored", rd, 32'hF);
		rst_i <= 1'b1;
		@(posedge sys_clk_i);
		rst_i <= 1'b0;
		@(posedge sys_clk_i);
		bus(0, 32'h98, 32'h0);
		check("power-on clears", rd, 32'h0);
		give_verdict;
	end
endmodule
